// ==== src/cct_timer.sv ====
// Purpose: 16-bit capture/compare timer behind a divide-by-4 prescaler
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   Flags, edge select and data registers ignore reset
// Function
// - Counter advances once every four clocks
// - Counter readable without disturbing count
// - Active capture edge copies counter
// - Edge select picks polarity, reset-immune
// - Compare every fourth clock drives level
// - Level bit sets pin value, reset clears
// - Three interrupt enables, cleared by reset
// - Capture flag cleared by status then low
// - Compare flag cleared by status then low access
// - Overflow flag on wrap, status then low
// - Counter high read freezes low; writes ignored
// - Alternate pair freezes, never clears overflow
// - Capture high read blocks capture until low
// - Compare high write suspends matching until low
// - Timer runs in wait; interrupt wakes
// - Stop halts counter; reset forces FFFC
// - Stop-mode edge armed, delivered on wake
// - Stop entry clears enables and prescaler
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module cct_timer (
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        capture_input_pin_in,
    output logic             compare_output_pin_out,
    input  wire logic        stop_mode_in,
    input  wire logic        wait_mode_in,
    output logic             irq_out,
    output logic             wake_out
);
    // ==========================================================
    // State
    logic [1:0]  presc_r;
    logic [15:0] cnt_r;
    logic [15:0] cap_r;
    logic [15:0] cmp_r;
    logic [2:0]  en_r;        // cap, cmp, ovf enables
    logic        edge_sel_r, level_r;
    logic        cap_flag_r, cmp_flag_r, ovf_flag_r;
    logic [2:0]  seen_r;      // flags seen set by status read
    logic [7:0]  cnt_lo_hold_r, alt_lo_hold_r;
    logic        cnt_hold_r, alt_hold_r;
    logic        cap_block_r, cmp_inh_r, armed_r;
    logic        pin_prev_r, stop_prev_r;
    logic [15:0] armed_val_r;
    logic        dp_wr_r;
    logic [5:0]  dp_idx_r;
    logic        hsize_word;

    // ==========================================================
    // Decode of the address phase
    logic        acc, rd, tick, pin_edge, cap_event, cmp_hit;
    logic        stop_entry, stop_exit, irq_nxt;
    logic        wr_cmp_hi, wr_cmp_lo, rd_cap_lo, rd_cmp_lo, rd_cnt_lo;
    logic [5:0]  idx;

    assign hsize_word = (hsize_in == 3'h2);
    assign acc  = hsel_in && hready_in && (htrans_in == cct_pkg::HTRANS_NSEQ);
    assign rd   = acc && !hwrite_in;
    assign idx  = haddr_in[7:2];
    // Prescaler wrap is the counter's advance point
    assign tick = (presc_r == cct_pkg::PRESC_LAST) && !stop_mode_in;
    assign stop_entry = stop_mode_in && !stop_prev_r;
    assign stop_exit  = !stop_mode_in && stop_prev_r;
    // Edge polarity chosen by the edge select bit
    assign pin_edge = edge_sel_r ? (capture_input_pin_in && !pin_prev_r)
                                 : (!capture_input_pin_in && pin_prev_r);
    assign cap_event = pin_edge && !cap_block_r && !stop_mode_in;
    assign cmp_hit = tick && !cmp_inh_r && (cnt_r == cmp_r);
    assign wr_cmp_hi = dp_wr_r && (dp_idx_r == cct_pkg::IDX_CMP_HI);
    assign wr_cmp_lo = dp_wr_r && (dp_idx_r == cct_pkg::IDX_CMP_LO);
    assign rd_cap_lo = rd && (idx == cct_pkg::IDX_CAP_LO);
    assign rd_cmp_lo = rd && (idx == cct_pkg::IDX_CMP_LO);
    assign rd_cnt_lo = rd && (idx == cct_pkg::IDX_CNT_LO);
    assign irq_nxt = (cap_flag_r && en_r[2]) || (cmp_flag_r && en_r[1])
                   || (ovf_flag_r && en_r[0]);

    // ==========================================================
    // Bus slave: zero wait, always OKAY, write in data phase
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            dp_wr_r       <= 1'b0;
            dp_idx_r      <= 6'h00;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            dp_wr_r       <= acc && hwrite_in && hsize_word;
            dp_idx_r      <= idx;
        end
    end

    // Read data latched at the address phase edge
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (rd) begin
            unique case (idx)
                cct_pkg::IDX_CTRL:
                    hrdata_out <= {24'h00_0000, en_r, 3'h0,
                                   edge_sel_r, level_r};
                cct_pkg::IDX_FLAGS:
                    hrdata_out <= {24'h00_0000, cap_flag_r, cmp_flag_r,
                                   ovf_flag_r, 5'h00};
                cct_pkg::IDX_CAP_HI: hrdata_out <= {24'h00_0000, cap_r[15:8]};
                cct_pkg::IDX_CAP_LO: hrdata_out <= {24'h00_0000, cap_r[7:0]};
                cct_pkg::IDX_CMP_HI: hrdata_out <= {24'h00_0000, cmp_r[15:8]};
                cct_pkg::IDX_CMP_LO: hrdata_out <= {24'h00_0000, cmp_r[7:0]};
                // Reads only sample; count path untouched
                cct_pkg::IDX_CNT_HI, cct_pkg::IDX_ALT_HI:
                    hrdata_out <= {24'h00_0000, cnt_r[15:8]};
                cct_pkg::IDX_CNT_LO:
                    hrdata_out <= {24'h00_0000, cnt_hold_r ? cnt_lo_hold_r
                                                           : cnt_r[7:0]};
                cct_pkg::IDX_ALT_LO:
                    hrdata_out <= {24'h00_0000, alt_hold_r ? alt_lo_hold_r
                                                           : cnt_r[7:0]};
                default: hrdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Prescaler and counter; reset exits stop at FFFC
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            presc_r <= cct_pkg::PRESC_RESET;
            cnt_r   <= cct_pkg::CNT_RESET;
        end else begin
            if (stop_mode_in) begin
                presc_r <= cct_pkg::PRESC_RESET;
            end else begin
                presc_r <= presc_r + 2'h1;
            end
            if (tick) begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Control register; edge select survives reset
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            en_r    <= cct_pkg::EN_RESET;
            level_r <= 1'b0;
        end else if (stop_entry) begin
            en_r <= cct_pkg::EN_RESET;
        end else if (dp_wr_r && dp_idx_r == cct_pkg::IDX_CTRL) begin
            en_r    <= {hwdata_in[cct_pkg::CTRL_CAP_IE],
                        hwdata_in[cct_pkg::CTRL_CMP_IE],
                        hwdata_in[cct_pkg::CTRL_OVF_IE]};
            level_r <= hwdata_in[cct_pkg::CTRL_LEVEL];
        end
    end

    // No reset term: the polarity choice is kept across resets
    always_ff @(posedge clock_in) begin
        if (nrst_in && dp_wr_r && dp_idx_r == cct_pkg::IDX_CTRL) begin
            edge_sel_r <= hwdata_in[cct_pkg::CTRL_EDGE];
        end
    end

    // ==========================================================
    // Pin and mode history for edge detection
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            pin_prev_r  <= capture_input_pin_in; // No false edge after reset
            stop_prev_r <= 1'b0;
        end else begin
            pin_prev_r  <= capture_input_pin_in;
            stop_prev_r <= stop_mode_in;
        end
    end

    // ==========================================================
    // Capture register, block window and stop-mode arming
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            cap_block_r <= 1'b0;
            armed_r     <= 1'b0;
            armed_val_r <= 16'h0000;
        end else begin
            if (rd && idx == cct_pkg::IDX_CAP_HI) begin
                cap_block_r <= 1'b1;
            end else if (rd_cap_lo) begin
                cap_block_r <= 1'b0;
            end
            // Only the first stop-mode edge is kept
            if (stop_mode_in && pin_edge && !armed_r) begin
                armed_r     <= 1'b1;
                armed_val_r <= cnt_r;
            end else if (stop_exit) begin
                armed_r <= 1'b0;
            end
        end
    end

    // Capture data is not reset, as the counter image it holds
    always_ff @(posedge clock_in) begin
        if (nrst_in && cap_event) begin
            cap_r <= cnt_r;
        end else if (nrst_in && stop_exit && armed_r) begin
            cap_r <= armed_val_r;
        end
    end

    // ==========================================================
    // Compare register and its inhibit window
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            cmp_inh_r <= 1'b0;
        end else if (wr_cmp_hi) begin
            cmp_inh_r <= 1'b1;
        end else if (wr_cmp_lo) begin
            cmp_inh_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (nrst_in && wr_cmp_hi) begin
            cmp_r[15:8] <= hwdata_in[7:0];
        end
        if (nrst_in && wr_cmp_lo) begin
            cmp_r[7:0] <= hwdata_in[7:0];
        end
    end

    // Pin follows the level bit on a match
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            compare_output_pin_out <= 1'b0;
        end else if (cmp_hit) begin
            compare_output_pin_out <= level_r;
        end
    end

    // ==========================================================
    // Low-byte freeze latches for both counter pairs
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            cnt_hold_r    <= 1'b0;
            alt_hold_r    <= 1'b0;
            cnt_lo_hold_r <= 8'h00;
            alt_lo_hold_r <= 8'h00;
        end else begin
            if (rd && idx == cct_pkg::IDX_CNT_HI) begin
                cnt_hold_r    <= 1'b1;
                cnt_lo_hold_r <= cnt_r[7:0];
            end else if (rd_cnt_lo) begin
                cnt_hold_r <= 1'b0;
            end
            if (rd && idx == cct_pkg::IDX_ALT_HI) begin
                alt_hold_r    <= 1'b1;
                alt_lo_hold_r <= cnt_r[7:0];
            end else if (rd && idx == cct_pkg::IDX_ALT_LO) begin
                alt_hold_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Status-read arming; a low access consumes it
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            seen_r <= 3'h0;
        end else if (rd && idx == cct_pkg::IDX_FLAGS) begin
            seen_r <= {cap_flag_r, cmp_flag_r, ovf_flag_r};
        end else begin
            if (rd_cap_lo) seen_r[2] <= 1'b0;
            if (rd_cmp_lo || wr_cmp_lo) seen_r[1] <= 1'b0;
            if (rd_cnt_lo) seen_r[0] <= 1'b0;
        end
    end

    // Flags ignore reset; a set in the clearing cycle wins
    always_ff @(posedge clock_in) begin
        if (cap_event || (nrst_in && stop_exit && armed_r)) begin
            cap_flag_r <= 1'b1;
        end else if (nrst_in && rd_cap_lo && seen_r[2]) begin
            cap_flag_r <= 1'b0;
        end
        if (nrst_in && cmp_hit) begin
            cmp_flag_r <= 1'b1;
        end else if (nrst_in && (rd_cmp_lo || wr_cmp_lo) && seen_r[1]) begin
            cmp_flag_r <= 1'b0;
        end
        if (nrst_in && tick && cnt_r == cct_pkg::CNT_ALL_ONE) begin
            ovf_flag_r <= 1'b1;
        end else if (nrst_in && rd_cnt_lo && seen_r[0]) begin
            ovf_flag_r <= 1'b0;
        end
    end

    // ==========================================================
    // Interrupt and wait-mode wake request
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            irq_out  <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            irq_out  <= irq_nxt;
            wake_out <= irq_nxt && wait_mode_in;
        end
    end

    // ==========================================================
    // Checks
    sequence s_stat_rd_ovf;
        rd && idx == cct_pkg::IDX_FLAGS && ovf_flag_r;
    endsequence
    sequence s_cnt_lo_rd;
        rd_cnt_lo && !(tick && cnt_r == cct_pkg::CNT_ALL_ONE);
    endsequence

    chk_presc_wrap: assert property (@(posedge clock_in) disable iff (!nrst_in)
        tick |=> presc_r == 2'h0 && cnt_r == $past(cnt_r) + 16'h0001)
        else $error("counter step wrong");
    chk_capture_copy: assert property (@(posedge clock_in)
        disable iff (!nrst_in) cap_event |=> cap_r == $past(cnt_r))
        else $error("capture value wrong");
    chk_cmp_drive: assert property (@(posedge clock_in)
        disable iff (!nrst_in)
        cmp_hit |=> compare_output_pin_out == $past(level_r) && cmp_flag_r)
        else $error("compare pin wrong");
    chk_ovf_clear: assert property (@(posedge clock_in)
        disable iff (!nrst_in)
        s_stat_rd_ovf ##[1:4] s_cnt_lo_rd |=> !ovf_flag_r)
        else $error("overflow flag not cleared");
    chk_cnt_freeze: assert property (@(posedge clock_in)
        disable iff (!nrst_in)
        cnt_hold_r && !rd |=> $stable(cnt_lo_hold_r))
        else $error("frozen low byte changed");
    chk_cmp_inhibit: assert property (@(posedge clock_in)
        disable iff (!nrst_in) wr_cmp_hi |=> !cmp_hit until wr_cmp_lo)
        else $error("compare during inhibit");
    chk_stop_halt: assert property (@(posedge clock_in)
        disable iff (!nrst_in) stop_mode_in [*2] |=> $stable(cnt_r))
        else $error("counter moved in stop");
    chk_reset_load: assert property (@(posedge clock_in)
        !nrst_in |=> cnt_r == cct_pkg::CNT_RESET && en_r == 3'h0)
        else $error("reset value wrong");
    chk_stop_entry: assert property (@(posedge clock_in)
        disable iff (!nrst_in)
        $rose(stop_mode_in) |=> en_r == 3'h0 && presc_r == 2'h0)
        else $error("stop entry not cleaned");
    chk_irq_follow: assert property (@(posedge clock_in)
        disable iff (!nrst_in)
        ((cap_flag_r && en_r[2]) || (cmp_flag_r && en_r[1])
         || (ovf_flag_r && en_r[0])) [*2] |-> irq_out)
        else $error("interrupt missing");
endmodule : cct_timer

// ==== src/cct_pkg.sv ====
// Purpose: Shared constants for the 16-bit capture/compare timer
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   Register index times four gives the byte address
package cct_pkg;
    // ==========================================================
    // Register indices (byte address = index * 4)
    localparam logic [5:0] IDX_CTRL     = 6'h12;
    localparam logic [5:0] IDX_FLAGS    = 6'h13;
    localparam logic [5:0] IDX_CAP_HI   = 6'h14;
    localparam logic [5:0] IDX_CAP_LO   = 6'h15;
    localparam logic [5:0] IDX_CMP_HI   = 6'h16;
    localparam logic [5:0] IDX_CMP_LO   = 6'h17;
    localparam logic [5:0] IDX_CNT_HI   = 6'h18;
    localparam logic [5:0] IDX_CNT_LO   = 6'h19;
    localparam logic [5:0] IDX_ALT_HI   = 6'h1A;
    localparam logic [5:0] IDX_ALT_LO   = 6'h1B;
    // ==========================================================
    // Control register fields
    localparam int CTRL_CAP_IE   = 7;
    localparam int CTRL_CMP_IE   = 6;
    localparam int CTRL_OVF_IE   = 5;
    localparam int CTRL_EDGE     = 1;
    localparam int CTRL_LEVEL    = 0;
    // Flag register fields
    localparam int FLG_CAP       = 7;
    localparam int FLG_CMP       = 6;
    localparam int FLG_OVF       = 5;
    // ==========================================================
    // Reset values and timing
    localparam logic [15:0] CNT_RESET   = 16'hFFFC;
    localparam logic [15:0] CNT_ALL_ONE = 16'hFFFF;
    localparam logic [1:0]  PRESC_LAST  = 2'h3;
    localparam logic [1:0]  PRESC_RESET = 2'h0;
    localparam logic [2:0]  EN_RESET    = 3'h0;
    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
endpackage : cct_pkg

// ==== sim/cct_pins.sv ====
// Purpose: Far-side pin model, capture source and compare monitor
// Assumes: Capture pin is a plain synchronous level
// Notes:   Pin moves only after a rising edge, never mid-cycle
`timescale 1ns/1ps
module cct_pins (
    input  wire logic clock_in,
    input  wire logic level_in,
    input  wire logic compare_pin_in,
    output logic      capture_pin_out,
    output int        toggles_out
);
    // ==========================================================
    // Capture source
    logic last_cmp_r;

    // Registered so edges never land on the sampling instant
    always_ff @(posedge clock_in) begin
        capture_pin_out <= level_in;
    end

    // ==========================================================
    // Compare monitor: count every level change on the pin
    initial begin
        toggles_out = 0;
        last_cmp_r  = 1'b0;
    end
    always @(posedge clock_in) begin
        // Unknown before the first reset edge is not a level change
        if ((compare_pin_in ^ last_cmp_r) === 1'b1) begin
            toggles_out <= toggles_out + 1;
        end
        last_cmp_r <= compare_pin_in;
    end
endmodule : cct_pins

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the capture/compare timer
// Assumes: Zero-wait AHB-Lite slave, 40 MHz clock
// Notes:   Counter deltas use exact cycle spacing of bus tasks
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // Signals
    logic        clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic        cap_pin, cap_lvl, cmp_pin, stop, wait_m, irq, wake;
    logic [15:0] v, f, h, l, a, b, t;
    int          bad_count, comparisons, toggles;

    assign hready = hreadyout;

    cct_timer cct_timer_i (
        .clock_in(clk), .nrst_in(nrst), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hreadyout),
        .hresp_out(hresp), .capture_input_pin_in(cap_pin),
        .compare_output_pin_out(cmp_pin), .stop_mode_in(stop),
        .wait_mode_in(wait_m), .irq_out(irq), .wake_out(wake));

    cct_pins cct_pins_i (
        .clock_in(clk), .level_in(cap_lvl), .compare_pin_in(cmp_pin),
        .capture_pin_out(cap_pin), .toggles_out(toggles));

    // ==========================================================
    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // One single transfer: address phase, then data phase
    task automatic bus(input logic [5:0] idx, input logic wr,
                       input logic [15:0] wd, output logic [15:0] rd);
        haddr  <= {idx, 2'b00};
        htrans <= cct_pkg::HTRANS_NSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata[15:0];
    endtask : bus

    task automatic rdr(input logic [5:0] idx, output logic [15:0] rd);
        bus(idx, 1'b0, 16'h0000, rd);
    endtask : rdr

    task automatic wrr(input logic [5:0] idx, input logic [15:0] wd);
        logic [15:0] dummy;
        bus(idx, 1'b1, wd, dummy);
    endtask : wrr

    // Alternate pair, high then low, four cycles in all
    task automatic alt(output logic [15:0] val);
        logic [15:0] hi, lo;
        rdr(cct_pkg::IDX_ALT_HI, hi);
        rdr(cct_pkg::IDX_ALT_LO, lo);
        val = {hi[7:0], lo[7:0]};
    endtask : alt

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset;
        nrst <= 1'b0;
        cyc(4);
        nrst <= 1'b1;
        cyc(1);
    endtask : do_reset

    task automatic test_done;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    // ==========================================================
    // Watchdog, well past the roughly 1500 cycles of the tests
    initial begin
        cyc(30000);
        bad_count++;
        $display("unexpected timeout at %0t", $time);
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        bad_count = 0;
        comparisons = 0;
        nrst = 1'b0; hsel = 1'b1; haddr = 8'h00; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0000_0000;
        cap_lvl = 1'b0; stop = 1'b0; wait_m = 1'b0;
        do_reset();
        // Reset values; edge select is unknown at power-up
        rdr(cct_pkg::IDX_CTRL, v);
        chk(v & 16'h00E1, 16'h0000);
        chk(16'(cmp_pin), 16'h0000);
        chk(16'(hresp), 16'h0000);
        rdr(cct_pkg::IDX_CNT_HI, v);
        chk(v, 16'h00FF);
        rdr(cct_pkg::IDX_CNT_LO, v);
        // Wrap from all ones sets overflow; alt low must not clear it
        cyc(20);
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0020, 16'h0020);
        rdr(cct_pkg::IDX_ALT_LO, v);
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0020, 16'h0020);
        rdr(cct_pkg::IDX_CNT_LO, v);
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0020, 16'h0000);
        // Rate: 400 cycles between high reads, ignored writes between
        alt(a);
        wrr(cct_pkg::IDX_CNT_LO, 16'h0055);
        wrr(cct_pkg::IDX_ALT_HI, 16'h0055);
        cyc(392);
        alt(b);
        chk(b - a, 16'h0064);
        // Low byte frozen from the high read, 204 cycles apart
        rdr(cct_pkg::IDX_CNT_HI, h);
        cyc(200);
        rdr(cct_pkg::IDX_CNT_LO, l);
        alt(b);
        chk(b - {h[7:0], l[7:0]}, 16'h0033);
        // Capture on rising edge, value between two snapshots
        wrr(cct_pkg::IDX_CTRL, 16'h0002);
        alt(a);
        cap_lvl <= 1'b1;
        cyc(3);
        alt(b);
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0080, 16'h0080);
        rdr(cct_pkg::IDX_CAP_HI, h);
        rdr(cct_pkg::IDX_CAP_LO, l);
        chk(16'(({h[7:0], l[7:0]} - a) <= (b - a)), 16'h0001);
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0080, 16'h0000);
        // Wrong polarity must not capture
        cap_lvl <= 1'b0;
        cyc(8);
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0080, 16'h0000);
        // High read blocks a later capture
        rdr(cct_pkg::IDX_CAP_HI, v);
        cap_lvl <= 1'b1;
        cyc(8);
        rdr(cct_pkg::IDX_CAP_LO, v);
        chk(v, l);
        // Falling select, then reset keeps flag and edge bit
        wrr(cct_pkg::IDX_CTRL, 16'h0000);
        cap_lvl <= 1'b0;
        cyc(4);
        wrr(cct_pkg::IDX_CTRL, 16'h00E3);
        do_reset();
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0080, 16'h0080);
        rdr(cct_pkg::IDX_CTRL, v);
        chk(v & 16'h00E3, 16'h0002);
        rdr(cct_pkg::IDX_CAP_LO, v);
        // Compare update in the safe order, level high
        wrr(cct_pkg::IDX_CTRL, 16'h0001);
        // A first match makes the power-up compare flag known
        alt(a);
        t = a + 16'h0008;
        wrr(cct_pkg::IDX_CMP_HI, {8'h00, t[15:8]});
        wrr(cct_pkg::IDX_CMP_LO, {8'h00, t[7:0]});
        cyc(40);
        chk(16'(cmp_pin), 16'h0001);
        alt(a);
        t = a + 16'h0028;
        wrr(cct_pkg::IDX_CMP_HI, {8'h00, t[15:8]});
        rdr(cct_pkg::IDX_FLAGS, f);
        wrr(cct_pkg::IDX_CMP_LO, {8'h00, t[7:0]});
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0040, 16'h0000);
        cyc(200);
        chk(16'(cmp_pin), 16'h0001);
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0040, 16'h0040);
        // Interrupt only once enabled; wake follows it in wait mode
        chk(16'(irq), 16'h0000);
        wrr(cct_pkg::IDX_CTRL, 16'h0041);
        cyc(2);
        chk(16'(irq), 16'h0001);
        wait_m <= 1'b1;
        cyc(2);
        chk(16'(wake), 16'h0001);
        wait_m <= 1'b0;
        rdr(cct_pkg::IDX_CMP_LO, v);
        chk(v, {8'h00, t[7:0]});
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0040, 16'h0000);
        chk(16'(irq), 16'h0000);
        // High write alone inhibits an otherwise due match, level low
        wrr(cct_pkg::IDX_CTRL, 16'h0000);
        alt(a);
        t = a + 16'h001E;
        wrr(cct_pkg::IDX_CMP_LO, {8'h00, t[7:0]});
        wrr(cct_pkg::IDX_CMP_HI, {8'h00, t[15:8]});
        cyc(200);
        chk(16'(cmp_pin), 16'h0001);
        alt(a);
        t = a + 16'h001E;
        wrr(cct_pkg::IDX_CMP_HI, {8'h00, t[15:8]});
        wrr(cct_pkg::IDX_CMP_LO, {8'h00, t[7:0]});
        cyc(200);
        chk(16'(cmp_pin), 16'h0000);
        chk(16'(toggles), 16'h0002);
        // Stop: enables cleared, counter frozen, edge armed
        wrr(cct_pkg::IDX_CTRL, 16'h00E2);
        stop <= 1'b1;
        cyc(2);
        rdr(cct_pkg::IDX_CTRL, v);
        chk(v & 16'h00E0, 16'h0000);
        alt(a);
        cap_lvl <= 1'b1;
        cyc(8);
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0080, 16'h0000);
        alt(b);
        chk(b, a);
        stop <= 1'b0;
        cyc(2);
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0080, 16'h0080);
        rdr(cct_pkg::IDX_CAP_HI, h);
        rdr(cct_pkg::IDX_CAP_LO, l);
        chk({h[7:0], l[7:0]}, a);
        // Stop left by reset: no capture, counter forced
        stop <= 1'b1;
        cap_lvl <= 1'b0;
        cyc(4);
        cap_lvl <= 1'b1;
        cyc(4);
        do_reset();
        rdr(cct_pkg::IDX_FLAGS, f);
        chk(f & 16'h0080, 16'h0000);
        alt(a);
        chk(a, cct_pkg::CNT_RESET);
        stop <= 1'b0;
        test_done();
    end
endmodule : tb_top
